/* File: wdh_pkg.sv */
// package for the watchdog, halt and reset sequencing block
// Overview of operation
// [R1] watchdog clock: RC oscillator or instruction clock
// [R2] disabled watchdog makes its actions no-ops
// [R3] timeout divider ratio 2^12 to 2^15
// [R4] clears reset only last two divider stages
// [R5] overflow in normal run: chip reset, timeout set
// [R6] overflow in halt: warm reset of counter, stack
// [R7] external reset, clear or halt clears watchdog
// [R8] dual-clear option needs both clear instructions
// [R9] halt stops system clock, watchdog restarts
// [R10] halt keeps RAM, registers and ports unchanged
// [R11] halt sets powerdown, clears timeout; clear clears powerdown
// [R12] wake on reset, interrupt, port A fall, overflow
// [R13] port or masked interrupt wake resumes next instruction
// [R14] interrupt pending before halt cannot wake
// [R15] 1024 clock delay after any wake-up
// [R16] timeout and powerdown flags encode reset cause
// [R17] start-up timer holds 1024 clocks after reset
// [R18] extra option load delay on system reset
// [R19] RC mode drives clock divided by 4 out
// [R20] instruction-clock watchdog may stop in halt
// [R21] reset beats warm reset beats interrupt or port
package wdh_pkg;
  localparam int unsigned WDH_DIV_MIN_LOG2 = 12;
  localparam int unsigned WDH_CNT_W        = 16;
  localparam int unsigned WDH_STARTUP_CYC  = 1024;
  localparam int unsigned WDH_OPTLOAD_CYC  = 16;
  localparam int unsigned WDH_DLY_W        = 11;
  localparam int unsigned WDH_INSTR_DIV    = 4;
  localparam int unsigned WDH_RC_PERIOD_NS = 65000;
  localparam int unsigned WDH_CLK_NS       = 10;
  localparam int unsigned WDH_RC_CYC =
    (WDH_RC_PERIOD_NS + WDH_CLK_NS - 1) / WDH_CLK_NS;

  typedef struct packed {
    logic       wdt_enable;
    logic       wdt_rc_sel;
    logic [1:0] div_sel;
    logic       dual_clear;
    logic       rc_osc_mode;
    logic [7:0] porta_wake_en;
  } wdh_opt_t;

  typedef struct packed {
    logic clr_single;
    logic clr_first;
    logic clr_second;
    logic halt;
  } wdh_instr_t;

  typedef enum logic [1:0] {
    WDH_RUN  = 2'b00,
    WDH_HALT = 2'b01,
    WDH_WAKE = 2'b10,
    WDH_RST  = 2'b11
  } wdh_state_t;
endpackage

/* File: wdh_ctrl.sv */
// watchdog, halt, wake-up and reset sequencing logic
module wdh_ctrl #(
  parameter int unsigned RC_CYC = wdh_pkg::WDH_RC_CYC
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // options and pins
  input  wire wdh_pkg::wdh_opt_t opt,
  input  wire logic              ext_reset_pin_n,
  input  wire logic [7:0]        porta_in,
  // core events
  input  wire wdh_pkg::wdh_instr_t instr,
  input  wire logic              irq_req,
  input  wire logic              irq_enabled,
  input  wire logic              stack_full,
  // outputs
  output logic                   chip_reset,
  output logic                   warm_reset,
  output logic                   core_run,
  output logic                   sys_osc_en,
  output logic                   irq_service,
  output logic                   osc_out_pin,
  output logic                   timeout_flag,
  output logic                   powerdown_flag
);
  localparam int unsigned DLYW = wdh_pkg::WDH_DLY_W;
  localparam logic [DLYW-1:0] STARTUP =
    DLYW'(wdh_pkg::WDH_STARTUP_CYC - 1);
  localparam logic [DLYW-1:0] RSTDLY =
    DLYW'(wdh_pkg::WDH_STARTUP_CYC + wdh_pkg::WDH_OPTLOAD_CYC - 1);

  wdh_pkg::wdh_state_t st_r, st_nxt;
  logic [DLYW-1:0] dly_r, dly_nxt;
  logic [wdh_pkg::WDH_CNT_W-1:0] cnt_r;
  logic [15:0] rc_r;
  logic [1:0]  div4_r;
  logic        first_seen_r, irq_block_r, irq_wake_r;
  logic [DLYW-1:0] len_r;
  logic [7:0]  porta_r;

  // watchdog tick source
  wire rc_tick   = (rc_r == 16'(RC_CYC - 1));
  wire halted    = (st_r == wdh_pkg::WDH_HALT);
  wire ins_tick  = (div4_r == 2'(wdh_pkg::WDH_INSTR_DIV - 1)) && !halted;
  wire wdt_tick  = opt.wdt_rc_sel ? rc_tick : ins_tick; // [R1] [R20]
  wire running   = (st_r == wdh_pkg::WDH_RUN);
  wire en        = opt.wdt_enable;

  // clear decoding
  wire clr_one   = en && running && !opt.dual_clear && instr.clr_single;
  wire clr_two   = en && running && opt.dual_clear &&
                   instr.clr_second && first_seen_r; // [R8]
  wire clr_pair  = en && running && opt.dual_clear &&
                   instr.clr_first && instr.clr_second;
  wire sw_clear  = clr_one || clr_two || clr_pair; // [R2] [R8]
  wire halt_go   = running && instr.halt;
  wire wdt_clear = sw_clear || halt_go || !ext_reset_pin_n; // [R7] [R9]

  // overflow at selected stage
  wire [4:0] ovf_bit = 5'(wdh_pkg::WDH_DIV_MIN_LOG2) + {3'h0, opt.div_sel};
  wire overflow  = en && wdt_tick &&
                   (cnt_r[ovf_bit[3:0]] && cnt_r[ovf_bit[3:0] - 4'h1]); // [R3]
  wire wdt_rst_run = overflow && running; // [R5]
  wire wdt_warm  = overflow && halted;    // [R6]

  wire [7:0] porta_fall = porta_r & ~porta_in & opt.porta_wake_en;
  wire irq_wake  = halted && irq_req && !irq_block_r; // [R14]
  wire port_wake = halted && (porta_fall != 8'h00);   // [R12]
  wire len_reload = !ext_reset_pin_n || wdt_rst_run ||
                    (halted && st_nxt == wdh_pkg::WDH_WAKE);

  // state sequencing with priority
  always_comb begin
    st_nxt  = st_r;
    dly_nxt = (dly_r != '0) ? dly_r - DLYW'(1) : dly_r;
    if (!ext_reset_pin_n || wdt_rst_run) begin // [R21]
      st_nxt  = wdh_pkg::WDH_RST;
      dly_nxt = RSTDLY; // [R17] [R18]
    end else begin
      unique case (st_r)
        wdh_pkg::WDH_RUN: begin
          if (instr.halt) st_nxt = wdh_pkg::WDH_HALT;
        end
        wdh_pkg::WDH_HALT: begin
          if (wdt_warm || irq_wake || port_wake) begin // [R12] [R21]
            st_nxt  = wdh_pkg::WDH_WAKE;
            dly_nxt = STARTUP; // [R15]
          end
        end
        wdh_pkg::WDH_WAKE, wdh_pkg::WDH_RST: begin
          if (dly_r == '0) st_nxt = wdh_pkg::WDH_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r  <= wdh_pkg::WDH_RST;
      dly_r <= RSTDLY;
    end else begin
      st_r  <= st_nxt;
      dly_r <= dly_nxt;
    end
  end

  // oscillator dividers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rc_r   <= 16'h0000;
      div4_r <= 2'h0;
    end else begin
      rc_r   <= rc_tick ? 16'h0000 : rc_r + 16'h0001;
      div4_r <= halted ? div4_r : div4_r + 2'h1; // [R9]
    end
  end

  // watchdog counter, clears touch only the top two stages
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (!en) begin
      cnt_r <= '0; // [R2]
    end else if (wdt_clear || overflow) begin
      cnt_r[ovf_bit[3:0]]        <= 1'b0; // [R4] [R7]
      cnt_r[ovf_bit[3:0] - 4'h1] <= 1'b0; // [R4]
    end else if (wdt_tick && st_r != wdh_pkg::WDH_RST) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // dual-clear tracking and wake bookkeeping
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_seen_r <= 1'b0;
      irq_block_r  <= 1'b0;
      irq_wake_r   <= 1'b0;
      len_r        <= '0;
      porta_r      <= 8'h00;
    end else begin
      porta_r <= porta_in;
      if (sw_clear) first_seen_r <= 1'b0;
      else if (en && running && opt.dual_clear && instr.clr_first)
        first_seen_r <= 1'b1; // [R8]
      if (halt_go) irq_block_r <= irq_req; // [R14]
      if (halted) irq_wake_r <= irq_wake && !wdt_warm && !port_wake;
      else if (st_r == wdh_pkg::WDH_RUN) irq_wake_r <= 1'b0;
      len_r <= len_reload ? '0 : len_r + DLYW'(1);
    end
  end

  // reset cause flags
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_flag   <= 1'b0; // [R16]
      powerdown_flag <= 1'b0;
    end else if (wdt_rst_run || wdt_warm) begin
      timeout_flag <= 1'b1; // [R5] [R16]
    end else if (!ext_reset_pin_n && halted) begin
      timeout_flag <= 1'b0; // [R16]
    end else if (halt_go) begin
      timeout_flag   <= 1'b0; // [R11]
      powerdown_flag <= 1'b1;
    end else if (en && sw_clear) begin
      timeout_flag   <= 1'b0; // [R11]
      powerdown_flag <= 1'b0;
    end
  end

  // registered control outputs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chip_reset  <= 1'b1;
      warm_reset  <= 1'b0;
      core_run    <= 1'b0;
      sys_osc_en  <= 1'b1;
      irq_service <= 1'b0;
      osc_out_pin <= 1'b0;
    end else begin
      chip_reset  <= (st_nxt == wdh_pkg::WDH_RST); // [R5] [R17]
      warm_reset  <= wdt_warm && ext_reset_pin_n; // [R6]
      core_run    <= (st_nxt == wdh_pkg::WDH_RUN); // [R10] [R15]
      sys_osc_en  <= (st_nxt != wdh_pkg::WDH_HALT); // [R9]
      irq_service <= (st_r == wdh_pkg::WDH_WAKE) && (dly_r == '0) &&
                     irq_wake_r && irq_enabled && !stack_full; // [R13]
      osc_out_pin <= opt.rc_osc_mode & div4_r[1]; // [R19]
    end
  end

  // multi-step behaviours
  sequence wake_entry_s;
    halted && ext_reset_pin_n && (wdt_warm || irq_wake || port_wake);
  endsequence

  sequence core_idle_s;
    !core_run [*8];
  endsequence

  sequence ext_low_s;
    !ext_reset_pin_n;
  endsequence

  sequence rst_hold_s;
    (chip_reset && !core_run) [*8];
  endsequence

  // flag and reset assertions
  halt_sets_pd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halt_go && ext_reset_pin_n && !overflow |=> powerdown_flag) // [R11]
    else $error("halt did not set powerdown flag");

  ovf_resets_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wdt_rst_run |=> chip_reset && timeout_flag) // [R5]
    else $error("overflow did not reset chip");

  warm_halt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wdt_warm && ext_reset_pin_n |=> warm_reset && !chip_reset) // [R6]
    else $error("halt overflow not warm reset");

  wake_delay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(st_r == wdh_pkg::WDH_WAKE) && ext_reset_pin_n
    |-> !core_run [*8]) // [R15]
    else $error("core ran during wake delay");

  ext_prio_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ext_reset_pin_n |=> chip_reset && !warm_reset) // [R21]
    else $error("external reset lost priority");

  osc_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halt_go && ext_reset_pin_n && !wdt_rst_run |=> !sys_osc_en) // [R9]
    else $error("oscillator not stopped in halt");

  dis_noop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !en |-> !overflow && !sw_clear) // [R2]
    else $error("disabled watchdog active");

  dis_clr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !en |=> cnt_r == '0) // [R2]
    else $error("disabled watchdog kept count");

  rc_out_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !opt.rc_osc_mode |=> !osc_out_pin) // [R19]
    else $error("clock out driven outside rc mode");

  wake_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wake_entry_s |=> core_idle_s) // [R15]
    else $error("core ran right after wake-up");

  rst_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ext_low_s |=> rst_hold_s) // [R17]
    else $error("reset not held after external reset");

  wake_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_r == wdh_pkg::WDH_WAKE && st_nxt == wdh_pkg::WDH_RUN
    |-> len_r == STARTUP) // [R15]
    else $error("wake delay length wrong");

  rst_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_r == wdh_pkg::WDH_RST && st_nxt == wdh_pkg::WDH_RUN
    |-> len_r == RSTDLY) // [R17] [R18]
    else $error("reset delay length wrong");

  irq_serv_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_service |-> $past(irq_enabled) && !$past(stack_full)) // [R13]
    else $error("interrupt serviced while refused");

  to_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wdt_warm |=> timeout_flag) // [R16]
    else $error("halt overflow did not set timeout");

  ext_halt_to_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ext_reset_pin_n && halted && !wdt_warm |=> !timeout_flag) // [R16]
    else $error("external wake kept timeout flag");

  halt_to_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halt_go && !overflow |=> !timeout_flag) // [R11]
    else $error("halt did not clear timeout flag");

  pd_clr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sw_clear && !overflow && !instr.halt
    |=> !powerdown_flag && !timeout_flag) // [R11]
    else $error("clear did not clear flags");

  pd_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halted && ext_reset_pin_n && !overflow
    |=> $stable(powerdown_flag)) // [R10]
    else $error("flag changed during halt");

  warm_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    warm_reset |=> !warm_reset) // [R6]
    else $error("warm reset longer than a cycle");

  // sequencing assertions
  core_st_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    core_run |-> st_r == wdh_pkg::WDH_RUN) // [R15]
    else $error("core ran outside run state");

  chip_st_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    chip_reset |-> st_r == wdh_pkg::WDH_RST) // [R17]
    else $error("chip reset outside reset state");

  halt_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halted |-> !core_run && !sys_osc_en) // [R9] [R10]
    else $error("core or oscillator active in halt");

  halt_enter_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halt_go && ext_reset_pin_n && !overflow |=> halted) // [R9]
    else $error("halt not entered");

  mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    halted && ext_reset_pin_n && !irq_wake && !wdt_warm && !port_wake
    |=> halted) // [R12]
    else $error("left halt without wake event");

  // watchdog counter assertions
  rc_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rc_tick |=> !rc_tick) // [R1]
    else $error("rc tick too frequent");

  ins_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ins_tick |=> !ins_tick [*3]) // [R1]
    else $error("instruction tick not divided by four");

  osc_rc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    opt.rc_osc_mode |=> osc_out_pin == $past(div4_r[1])) // [R19]
    else $error("clock out not divided clock");

  wdt_clr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wdt_clear |=> !cnt_r[ovf_bit[3:0]] &&
    !cnt_r[ovf_bit[3:0] - 4'h1]) // [R4] [R7]
    else $error("clear left top stages set");

  ins_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !opt.wdt_rc_sel && halted && ext_reset_pin_n && en
    |=> $stable(cnt_r)) // [R20]
    else $error("instruction clock watchdog ran in halt");
endmodule // wdh_ctrl

/* File: wdh_ctrl_bench.sv */
// self-checking bench for the watchdog, halt and reset block
module wdh_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                sys_clk;
  logic                sys_rst;
  wdh_pkg::wdh_opt_t   opt;
  logic                ext_reset_pin_n;
  logic [7:0]          porta_in;
  wdh_pkg::wdh_instr_t instr;
  logic                irq_req;
  logic                irq_enabled;
  logic                stack_full;
  logic                chip_reset, warm_reset, core_run, sys_osc_en;
  logic                irq_service, osc_out_pin;
  logic                timeout_flag, powerdown_flag;
  logic                saw_rst, saw_irq, a;
  int                  failures, n_tests, cyc, n;

  wdh_ctrl #(.RC_CYC(2)) i_wdh_ctrl (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .opt(opt),
    .ext_reset_pin_n(ext_reset_pin_n), .porta_in(porta_in),
    .instr(instr), .irq_req(irq_req), .irq_enabled(irq_enabled),
    .stack_full(stack_full), .chip_reset(chip_reset),
    .warm_reset(warm_reset), .core_run(core_run),
    .sys_osc_en(sys_osc_en), .irq_service(irq_service),
    .osc_out_pin(osc_out_pin), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // sticky monitors and run limit
  always @(posedge sys_clk) begin
    cyc++;
    if (chip_reset === 1'h1) saw_rst <= 1'h1;
    if (irq_service === 1'h1) saw_irq <= 1'h1;
    if (cyc == 80000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic pulse(input wdh_pkg::wdh_instr_t v);
    instr = v;
    tick();
    instr = 4'h0;
  endtask

  // sel 0 core_run, 1 chip_reset, 2 warm_reset
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (n < lim && !(sel == 0 ? core_run === 1'h1 :
           sel == 1 ? chip_reset === 1'h1 : warm_reset === 1'h1)) begin
      tick();
      n++;
    end
  endtask

  task automatic in_range(input string nm, input int lo, input int hi);
    check(nm, {15'h0, n >= lo && n <= hi}, 16'h1);
  endtask

  task automatic flags(input logic t, input logic p);
    check("timeout_flag", {15'h0, timeout_flag}, {15'h0, t});
    check("powerdown_flag", {15'h0, powerdown_flag}, {15'h0, p});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    sys_rst = 1'h1;
    opt = {1'h1, 1'h1, 2'h0, 1'h0, 1'h1, 8'h01};
    ext_reset_pin_n = 1'h1;
    porta_in = 8'hFF;
    instr = 4'h0;
    {irq_req, irq_enabled, stack_full} = 3'h2;
    {saw_rst, saw_irq} = 2'h0;
    {failures, n_tests, cyc} = '0;
    repeat (4) tick();
    check("chip_reset", {15'h0, chip_reset}, 16'h1);
    flags(1'h0, 1'h0);
    sys_rst = 1'h0;
    wait_for(0, 1100);
    in_range("startup", 1039, 1046);
    $display("test startup done");
    repeat (3) begin
      a = osc_out_pin;
      repeat (2) tick();
      check("osc_out_pin", {15'h0, osc_out_pin}, {15'h0, ~a});
    end
    saw_rst = 1'h0;
    repeat (3) begin
      repeat (7000) tick();
      pulse(4'h8);
    end
    check("no_timeout", {15'h0, saw_rst}, 16'h0);
    $display("test clears done");
    irq_req = 1'h1;
    pulse(4'h1);
    check("sys_osc_en", {15'h0, sys_osc_en}, 16'h0);
    check("core_run", {15'h0, core_run}, 16'h0);
    flags(1'h0, 1'h1);
    repeat (20) tick();
    porta_in = 8'hFE;
    wait_for(0, 1100);
    in_range("port_wake", 1024, 1030);
    check("no_irq", {15'h0, saw_irq}, 16'h0);
    check("sys_osc_en", {15'h0, sys_osc_en}, 16'h1);
    pulse(4'h8);
    flags(1'h0, 1'h0);
    porta_in = 8'hFF;
    irq_req = 1'h0;
    $display("test port wake done");
    pulse(4'h1);
    repeat (5) tick();
    irq_req = 1'h1;
    wait_for(0, 1100);
    in_range("irq_wake", 1024, 1030);
    repeat (3) tick();
    check("irq_service", {15'h0, saw_irq}, 16'h1);
    irq_req = 1'h0;
    pulse(4'h8);
    $display("test irq wake done");
    wait_for(1, 17000);
    in_range("run_timeout", 8000, 16500);
    flags(1'h1, 1'h0);
    wait_for(0, 1100);
    in_range("run_restart", 1039, 1046);
    $display("test run timeout done");
    saw_rst = 1'h0;
    pulse(4'h1);
    flags(1'h0, 1'h1);
    wait_for(2, 17000);
    in_range("halt_timeout", 8000, 16500);
    tick();
    flags(1'h1, 1'h1);
    check("no_chip_reset", {15'h0, saw_rst}, 16'h0);
    wait_for(0, 1100);
    in_range("warm_wake", 1022, 1030);
    $display("test halt timeout done");
    pulse(4'h1);
    ext_reset_pin_n = 1'h0;
    repeat (2) tick();
    check("chip_reset", {15'h0, chip_reset}, 16'h1);
    flags(1'h0, 1'h1);
    ext_reset_pin_n = 1'h1;
    wait_for(0, 1100);
    in_range("ext_wake", 1039, 1046);
    ext_reset_pin_n = 1'h0;
    repeat (2) tick();
    ext_reset_pin_n = 1'h1;
    flags(1'h0, 1'h1);
    $display("test external reset done");
    wait_for(0, 1100);
    in_range("ext_run", 1039, 1046);
    opt.dual_clear = 1'h1;
    pulse(4'h8);
    flags(1'h0, 1'h1);
    pulse(4'h4);
    flags(1'h0, 1'h1);
    pulse(4'h2);
    flags(1'h0, 1'h0);
    pulse(4'h1);
    repeat (3) tick();
    porta_in = 8'hFE;
    wait_for(0, 1100);
    in_range("dual_wake", 1024, 1030);
    porta_in = 8'hFF;
    opt.wdt_enable = 1'h0;
    pulse(4'h6);
    flags(1'h0, 1'h1);
    $display("test clear options done");
    wrap_up();
  end
endmodule // wdh_ctrl_bench
